/* File: hw/bitmap_fragment_rasterizer.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Bit FIFO
// ------------------------------------------------------------
module bit_fifo #(
    parameter int WIDTH = 1,
    parameter int DEPTH = 8
) (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Fill side
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    // Drain side
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CNT_W = $clog2(DEPTH + 1);
    localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
    localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

    typedef struct packed {
        logic [PTR_W-1:0] wr_ptr;
        logic [PTR_W-1:0] rd_ptr;
        logic [CNT_W-1:0] count;
        logic not_full;
    } fifo_s;

    localparam fifo_s FIFO_RESET = '{not_full: 1'b1, default: '0};

    fifo_s r;
    fifo_s next_r;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    assign push = in_valid && r.not_full;
    assign pop = out_valid && out_ready;
    assign in_ready = r.not_full;
    assign out_valid = (r.count != '0);
    assign out_data = mem[r.rd_ptr];

    always_comb begin
        next_r = r;
        if (push) begin
            next_r.wr_ptr = (r.wr_ptr == PTR_LAST) ? '0 : PTR_W'(r.wr_ptr + 1'b1);
        end
        if (pop) begin
            next_r.rd_ptr = (r.rd_ptr == PTR_LAST) ? '0 : PTR_W'(r.rd_ptr + 1'b1);
        end
        if (push && !pop) begin
            next_r.count = CNT_W'(r.count + 1'b1);
        end else if (pop && !push) begin
            next_r.count = CNT_W'(r.count - 1'b1);
        end
        next_r.not_full = (next_r.count != CNT_FULL);
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= FIFO_RESET;
        end else begin
            r <= next_r;
        end
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[r.wr_ptr] <= in_data;
        end
    end

endmodule : bit_fifo

// Contract
// - Invalid raster position: drop bitmap, keep position
// - Lower-left corner is floor of position minus origin
// - Fragment only where bitmap bit is one
// - All fragments carry raster position data
// - Add increments to position x and y
// - Position z and w stay unchanged
// - Multisample when enabled and one sample buffer
// - Multisample rectangles start at raster position
// - Multisample rectangle dropped for zero bit
// - Fragment per pixel with covered sample
// - Coverage one inside or bottom-left edge
// - Multisample sample data from raster position
// - Multisample advances position like single-sample
module bitmap_fragment_rasterizer (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Raster position load
    input wire logic rp_load,
    input wire raster_pkg::raster_pos_s rp_in,
    // Bitmap command
    input wire logic cmd_valid,
    input wire raster_pkg::bitmap_cmd_s cmd,
    output logic cmd_ready,
    // Bitmap bit stream
    input wire logic bit_valid,
    input wire logic bit_data,
    output logic bit_ready,
    // Fragment stream
    output logic frag_valid,
    output raster_pkg::fragment_s frag,
    input wire logic frag_ready,
    // Status
    output raster_pkg::raster_pos_s raster_pos,
    output logic bitmap_done
);
    import raster_pkg::*;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic coord_t to_pixel(input pos_t p);
        return p[FRAC_BITS +: COORD_W];
    endfunction : to_pixel

    function automatic pos_t dim_to_pos(input dim_t d);
        return pos_t'({d, {FRAC_BITS{1'b0}}});
    endfunction : dim_to_pos

    function automatic cov_t sample_cover(input pos_t rx, input pos_t ry,
                                          input coord_t px, input coord_t py);
        pos_t sx;
        pos_t sy;
        cov_t c;
        c = '0;
        for (int s = 0; s < SAMPLES; s++) begin
            sx = pos_t'({px, SAMPLE_OFF_X[s]});
            sy = pos_t'({py, SAMPLE_OFF_Y[s]});
            c[s] = (sx >= rx) && (sx < pos_t'(rx + PIXEL_ONE))
                && (sy >= ry) && (sy < pos_t'(ry + PIXEL_ONE));
        end
        return c;
    endfunction : sample_cover

    // ------------------------------------------------------------
    // Input buffering
    // ------------------------------------------------------------
    logic fifo_valid;
    logic fifo_data;
    logic fifo_pop;

    bit_fifo #(
        .WIDTH(1),
        .DEPTH(FIFO_DEPTH)
    ) u_bit_fifo (
        .clk(clk),
        .reset_n(reset_n),
        .in_valid(bit_valid),
        .in_data(bit_data),
        .in_ready(bit_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_data),
        .out_ready(fifo_pop)
    );

    // ------------------------------------------------------------
    // Rasterizer state
    // ------------------------------------------------------------
    raster_s r;
    raster_s next_r;
    logic out_free;
    logic scan_last;
    logic cmd_take;
    logic ss_emit;
    coord_t ss_x;
    coord_t ss_y;
    pos_t ms_rx;
    pos_t ms_ry;
    coord_t ms_px;
    coord_t ms_py;
    cov_t ms_cov;

    assign out_free = !r.frag_valid || frag_ready;
    assign scan_last = (r.col == dim_t'(r.cmd.w - 1'b1)) && (r.row == dim_t'(r.cmd.h - 1'b1));
    assign cmd_take = (r.state == ST_IDLE) && cmd_valid && r.cmd_ready;
    assign ss_x = coord_t'(r.xll + coord_t'({8'h00, r.col}));
    assign ss_y = coord_t'(r.yll + coord_t'({8'h00, r.row}));
    assign ms_rx = pos_t'(r.rp.x + dim_to_pos(r.col));
    assign ms_ry = pos_t'(r.rp.y + dim_to_pos(r.row));
    assign ms_px = coord_t'(to_pixel(ms_rx) + coord_t'({15'h0000, r.quad[0]}));
    assign ms_py = coord_t'(to_pixel(ms_ry) + coord_t'({15'h0000, r.quad[1]}));
    assign ms_cov = sample_cover(ms_rx, ms_ry, ms_px, ms_py);
    assign ss_emit = (r.state == ST_SCAN) && fifo_valid && out_free && !r.ms
        && fifo_data && r.rp.valid;

    always_comb begin
        next_r = r;
        next_r.done = 1'b0;
        fifo_pop = 1'b0;
        if (r.frag_valid && frag_ready) begin
            next_r.frag_valid = 1'b0;
        end
        case (r.state)
            ST_IDLE: begin
                if (rp_load) begin
                    next_r.rp = rp_in;
                end
                if (cmd_take) begin
                    next_r.cmd = cmd;
                    next_r.ms = cmd.ms_enable && (cmd.sample_buffer_count == SBUF_MULTI);
                    next_r.col = '0;
                    next_r.row = '0;
                    next_r.quad = '0;
                    next_r.xll = to_pixel(pos_t'(r.rp.x - cmd.x_origin));
                    next_r.yll = to_pixel(pos_t'(r.rp.y - cmd.y_origin));
                    next_r.cmd_ready = 1'b0;
                    if (cmd.w == '0 || cmd.h == '0) begin
                        next_r.state = ST_UPDATE;
                    end else begin
                        next_r.state = ST_SCAN;
                    end
                end
            end
            ST_SCAN: begin
                if (fifo_valid && out_free) begin
                    if (r.ms && fifo_data && r.rp.valid) begin
                        next_r.quad = '0;
                        next_r.state = ST_MS_EMIT;
                    end else begin
                        fifo_pop = 1'b1;
                        if (ss_emit) begin
                            next_r.frag_valid = 1'b1;
                            next_r.frag.x = ss_x;
                            next_r.frag.y = ss_y;
                            next_r.frag.coverage = COV_FULL;
                            next_r.frag.assoc = r.rp.assoc;
                        end
                        if (scan_last) begin
                            next_r.state = ST_UPDATE;
                        end else if (r.col == dim_t'(r.cmd.w - 1'b1)) begin
                            next_r.col = '0;
                            next_r.row = dim_t'(r.row + 1'b1);
                        end else begin
                            next_r.col = dim_t'(r.col + 1'b1);
                        end
                    end
                end
            end
            ST_MS_EMIT: begin
                if (out_free) begin
                    if (ms_cov != '0) begin
                        next_r.frag_valid = 1'b1;
                        next_r.frag.x = ms_px;
                        next_r.frag.y = ms_py;
                        next_r.frag.coverage = ms_cov;
                        next_r.frag.assoc = r.rp.assoc;
                    end
                    next_r.quad = 2'(r.quad + 1'b1);
                    if (r.quad == 2'h3) begin
                        fifo_pop = 1'b1;
                        if (scan_last) begin
                            next_r.state = ST_UPDATE;
                        end else begin
                            next_r.state = ST_SCAN;
                            if (r.col == dim_t'(r.cmd.w - 1'b1)) begin
                                next_r.col = '0;
                                next_r.row = dim_t'(r.row + 1'b1);
                            end else begin
                                next_r.col = dim_t'(r.col + 1'b1);
                            end
                        end
                    end
                end
            end
            ST_UPDATE: begin
                if (r.rp.valid) begin
                    next_r.rp.x = pos_t'(r.rp.x + r.cmd.x_inc);
                    next_r.rp.y = pos_t'(r.rp.y + r.cmd.y_inc);
                end
                next_r.done = 1'b1;
                next_r.cmd_ready = 1'b1;
                next_r.state = ST_IDLE;
            end
            default: begin
                next_r = RASTER_RESET;
            end
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            r <= RASTER_RESET;
        end else begin
            r <= next_r;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign cmd_ready = r.cmd_ready;
    assign frag_valid = r.frag_valid;
    assign frag = r.frag;
    assign raster_pos = r.rp;
    assign bitmap_done = r.done;

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    a_invalid_no_frag: assert property (
        $rose(frag_valid) |-> r.rp.valid)
        else $error("fragment emitted with invalid raster position");

    a_invalid_pos_hold: assert property (
        bitmap_done && !raster_pos.valid |-> $stable(raster_pos.x) && $stable(raster_pos.y))
        else $error("invalid raster position was moved");

    a_ss_corner_pos: assert property (
        ss_emit |=> frag_valid && frag.x == $past(ss_x) && frag.y == $past(ss_y)
            && frag.coverage == COV_FULL)
        else $error("single-sample fragment at wrong position");

    a_clear_bit_none: assert property (
        fifo_pop && !fifo_data |=> !frag_valid)
        else $error("fragment emitted for cleared bit");

    a_assoc_data_same: assert property (
        frag_valid && r.state != ST_IDLE |-> frag.assoc == r.rp.assoc)
        else $error("fragment data differs from raster position");

    a_pos_advance_xy: assert property (
        r.state == ST_UPDATE && r.rp.valid ##1 bitmap_done |->
            raster_pos.x == pos_t'($past(r.rp.x) + r.cmd.x_inc)
            && raster_pos.y == pos_t'($past(r.rp.y) + r.cmd.y_inc))
        else $error("raster position not advanced by increments");

    a_pos_zw_stable: assert property (
        bitmap_done |-> $stable(raster_pos.z) && $stable(raster_pos.w))
        else $error("raster position z or w changed");

    a_ms_mode_select: assert property (
        cmd_take |=> r.ms == ($past(cmd.ms_enable)
            && $past(cmd.sample_buffer_count) == SBUF_MULTI))
        else $error("wrong rasterization mode selected");

    a_ms_zero_drop: assert property (
        r.state == ST_SCAN && r.ms && fifo_valid && !fifo_data && out_free
        |=> r.state != ST_MS_EMIT)
        else $error("multisample rectangle kept for zero bit");

    a_ms_cov_nonzero: assert property (
        r.state == ST_MS_EMIT && out_free && ms_cov != '0 |=> frag_valid
            && frag.coverage == $past(ms_cov))
        else $error("covered pixel produced no fragment");

    a_done_after_scan: assert property (
        bitmap_done |-> $past(r.state) == ST_UPDATE && !$past(bitmap_done))
        else $error("completion outside update");

    c_ss_fragment: cover property (ss_emit ##1 frag_valid && frag_ready);
    c_ms_fragment: cover property (r.state == ST_MS_EMIT && ms_cov == COV_FULL);
    c_invalid_done: cover property (bitmap_done && !raster_pos.valid);
    c_fifo_full: cover property (!bit_ready ##[1:300] bitmap_done);

endmodule : bitmap_fragment_rasterizer

`default_nettype wire

/* File: inc/raster_pkg.sv */
`default_nettype none

package raster_pkg;

    // ------------------------------------------------------------
    // Widths and fixed-point format
    // ------------------------------------------------------------
    localparam int FRAC_BITS = 8;
    localparam int POS_W = 24;
    localparam int COORD_W = 16;
    localparam int DIM_W = 8;
    localparam int ATTR_W = 64;
    localparam int SAMPLES = 4;
    localparam int SBUF_W = 4;
    localparam int FIFO_DEPTH = 8;

    typedef logic signed [POS_W-1:0] pos_t;
    typedef logic signed [COORD_W-1:0] coord_t;
    typedef logic [DIM_W-1:0] dim_t;
    typedef logic [SAMPLES-1:0] cov_t;

    // ------------------------------------------------------------
    // Constants
    // ------------------------------------------------------------
    localparam pos_t PIXEL_ONE = 24'h00_0100;
    localparam logic [SBUF_W-1:0] SBUF_MULTI = 4'h1;
    localparam cov_t COV_FULL = 4'hF;
    localparam logic [7:0] SAMPLE_OFF_X [SAMPLES] = '{8'h60, 8'hE0, 8'h20, 8'hA0};
    localparam logic [7:0] SAMPLE_OFF_Y [SAMPLES] = '{8'h20, 8'h60, 8'hA0, 8'hE0};

    // ------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------
    typedef struct packed {
        dim_t w;
        dim_t h;
        pos_t x_origin;
        pos_t y_origin;
        pos_t x_inc;
        pos_t y_inc;
        logic ms_enable;
        logic [SBUF_W-1:0] sample_buffer_count;
    } bitmap_cmd_s;

    typedef struct packed {
        pos_t x;
        pos_t y;
        pos_t z;
        pos_t w;
        logic valid;
        logic [ATTR_W-1:0] assoc;
    } raster_pos_s;

    typedef struct packed {
        coord_t x;
        coord_t y;
        cov_t coverage;
        logic [ATTR_W-1:0] assoc;
    } fragment_s;

    typedef enum logic [1:0] {ST_IDLE, ST_SCAN, ST_MS_EMIT, ST_UPDATE} raster_state_e;

    typedef struct packed {
        raster_state_e state;
        raster_pos_s rp;
        bitmap_cmd_s cmd;
        dim_t col;
        dim_t row;
        logic ms;
        coord_t xll;
        coord_t yll;
        logic [1:0] quad;
        logic cmd_ready;
        logic frag_valid;
        fragment_s frag;
        logic done;
    } raster_s;

    localparam raster_s RASTER_RESET = '{state: ST_IDLE, cmd_ready: 1'b1, default: '0};

endpackage : raster_pkg

`default_nettype wire

/* File: verification/bitmap_fragment_rasterizer_tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module bitmap_fragment_rasterizer_tb_top;
    import raster_pkg::*;

    logic clk, reset_n, rp_load, cmd_valid, cmd_ready, bit_ready, frag_valid;
    logic frag_ready, bitmap_done;
    logic bit_valid = 1'b0;
    logic bit_data = 1'b0;
    logic [7:0] stall;
    raster_pos_s rp_in, raster_pos, rpm, hold;
    bitmap_cmd_s cmd;
    fragment_s frag;
    fragment_s expq[$];
    bit bitq[$];
    int bad_count, check_count;
    integer seed;

    bitmap_fragment_rasterizer dut (.clk(clk), .reset_n(reset_n), .rp_load(rp_load),
        .rp_in(rp_in), .cmd_valid(cmd_valid), .cmd(cmd), .cmd_ready(cmd_ready),
        .bit_valid(bit_valid), .bit_data(bit_data), .bit_ready(bit_ready),
        .frag_valid(frag_valid), .frag(frag), .frag_ready(frag_ready),
        .raster_pos(raster_pos), .bitmap_done(bitmap_done));

    frag_sink sink (.clk(clk), .reset_n(reset_n), .stall(stall), .frag_ready(frag_ready));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // ------------------------------------------------------------
    // Checking and closing
    // ------------------------------------------------------------
    task automatic check(input logic [255:0] seen, input logic [255:0] exp, input string what);
        check_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("[FAIL] %0t %s", $time, what);
        end
    endtask : check

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude

    // ------------------------------------------------------------
    // Bit feeder and fragment monitor
    // ------------------------------------------------------------
    always @(posedge clk) begin
        if (bit_valid && bit_ready) begin
            void'(bitq.pop_front());
        end
        bit_valid <= (bitq.size() > 0);
        bit_data <= (bitq.size() > 0) ? bitq[0] : ~bit_data;
    end

    always @(posedge clk) begin
        if (reset_n && frag_valid && frag_ready) begin
            if (expq.size() == 0) begin
                check(1, 0, "unexpected fragment");
            end else begin
                check(frag, expq.pop_front(), "fragment");
            end
        end
    end

    // ------------------------------------------------------------
    // Stimulus helpers
    // ------------------------------------------------------------
    function automatic raster_pos_s mkrp(int x, int y, bit v);
        raster_pos_s p;
        p.x = x[23:0];
        p.y = y[23:0];
        p.z = $random(seed);
        p.w = $random(seed);
        p.valid = v;
        p.assoc = {$random(seed), $random(seed)};
        return p;
    endfunction : mkrp

    function automatic bitmap_cmd_s mkcmd(int w, int h, int xo, int yo, int xi, int yi,
                                          bit ms, int sb);
        bitmap_cmd_s c;
        c.w = w[7:0];
        c.h = h[7:0];
        c.x_origin = xo[23:0];
        c.y_origin = yo[23:0];
        c.x_inc = xi[23:0];
        c.y_inc = yi[23:0];
        c.ms_enable = ms;
        c.sample_buffer_count = sb[3:0];
        return c;
    endfunction : mkcmd

    task automatic load(input raster_pos_s p);
        @(posedge clk);
        rp_load <= 1'b1;
        rp_in <= p;
        @(posedge clk);
        rp_load <= 1'b0;
        @(posedge clk);
        #1 check(raster_pos, p, "position load");
        rpm = p;
    endtask : load

    // Queue bits and note every fragment expected from them
    task automatic plan(input bitmap_cmd_s c, input bit b[$]);
        int k, xr, yr, px, py, sx, sy;
        bit ms;
        fragment_s f;
        ms = c.ms_enable && (c.sample_buffer_count == 4'h1);
        for (int r = 0; r < c.h; r++) begin
            for (int col = 0; col < c.w; col++) begin
                k = r * c.w + col;
                bitq.push_back(b[k]);
                f = '0;
                f.assoc = rpm.assoc;
                if (rpm.valid && b[k] && !ms) begin
                    px = ((int'(rpm.x) - int'(c.x_origin)) >>> 8) + col;
                    py = ((int'(rpm.y) - int'(c.y_origin)) >>> 8) + r;
                    f.x = px[15:0];
                    f.y = py[15:0];
                    f.coverage = COV_FULL;
                    expq.push_back(f);
                end else if (rpm.valid && b[k]) begin
                    xr = int'(rpm.x) + col * 256;
                    yr = int'(rpm.y) + r * 256;
                    for (int q = 0; q < 4; q++) begin
                        px = (xr >>> 8) + q[0];
                        py = (yr >>> 8) + q[1];
                        for (int s = 0; s < SAMPLES; s++) begin
                            sx = px * 256 + int'(SAMPLE_OFF_X[s]);
                            sy = py * 256 + int'(SAMPLE_OFF_Y[s]);
                            f.coverage[s] = xr <= sx && sx < xr + 256 && yr <= sy && sy < yr + 256;
                        end
                        f.x = px[15:0];
                        f.y = py[15:0];
                        if (f.coverage != '0) begin
                            expq.push_back(f);
                        end
                    end
                end
            end
        end
        if (rpm.valid) begin
            rpm.x = rpm.x + c.x_inc;
            rpm.y = rpm.y + c.y_inc;
        end
    endtask : plan

    task automatic issue(input bitmap_cmd_s c);
        int k;
        logic r;
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd <= c;
        k = 0;
        do begin
            #1 r = cmd_ready;
            @(posedge clk);
            k++;
        end while (r !== 1'b1 && k < 100);
        cmd_valid <= 1'b0;
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (bitmap_done !== 1'b1 && k < 3000);
        check(bitmap_done, 1'b1, "completion pulse");
        check(raster_pos, rpm, "position update");
        check({raster_pos.z, raster_pos.w}, {rpm.z, rpm.w}, "z and w kept");
        k = 0;
        while (expq.size() > 0 && k < 3000) begin
            @(posedge clk);
            k++;
        end
        check(expq.size(), 0, "missing fragments");
    endtask : issue

    task automatic run(input bitmap_cmd_s c);
        bit b[$];
        for (int i = 0; i < c.w * c.h; i++) begin
            b.push_back($random(seed));
        end
        plan(c, b);
        issue(c);
    endtask : run

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        bit ones[$];
        int k;
        seed = 32'h8829_a700;
        reset_n = 1'b0;
        rp_load = 1'b0;
        rp_in = '0;
        cmd_valid = 1'b0;
        cmd = '0;
        stall = 8'h00;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        #1 check({cmd_ready, bit_ready, frag_valid, bitmap_done}, 4'hC, "reset outputs");
        check(raster_pos, 0, "reset position");
        $display("test reset done");

        stall = 8'h32;
        load(mkrp(32'h0000_0a40, 32'h0000_0500, 1'b1));
        run(mkcmd(5, 3, 32'h0000_0180, -128, 32'h0000_0340, 32'h0000_0100, 1'b0, 0));
        run(mkcmd(4, 2, 32'h0000_1000, 0, -256, 32'h0000_0200, 1'b0, 0));
        $display("test single sample done");

        stall = 8'h64;
        for (int i = 0; i < 12; i++) begin
            ones.push_back(1'b1);
        end
        plan(mkcmd(4, 3, 0, 0, 32'h0000_0400, 0, 1'b0, 0), ones);
        k = 0;
        do begin
            @(posedge clk);
            #1 k++;
        end while (bit_ready !== 1'b0 && k < 50);
        check(bit_ready, 1'b0, "bit buffer full");
        check(bitq.size(), 4, "bit buffer holds eight");
        stall = 8'h46;
        issue(mkcmd(4, 3, 0, 0, 32'h0000_0400, 0, 1'b0, 0));
        check(bit_ready, 1'b1, "bit buffer drained");
        $display("test buffer done");

        stall = 8'h1e;
        load(mkrp(32'h0000_0a40, 32'h0000_0390, 1'b1));
        for (int i = 0; i < 4; i++) begin
            run(mkcmd(3, 2, 32'h0000_0080, 0, 32'h0000_0160, 32'h0000_0030, i != 2,
                      (i == 1) ? 2 : 1));
        end
        $display("test multisample done");

        hold = mkrp(32'h0000_0200, 32'h0000_0300, 1'b0);
        load(hold);
        run(mkcmd(3, 2, 0, 0, 32'h0000_0100, 32'h0000_0100, 1'b0, 0));
        check(raster_pos, hold, "invalid position kept");
        check(bitq.size(), 0, "bits consumed");
        $display("test invalid position done");

        load(mkrp(32'h0000_0100, 32'h0000_0100, 1'b1));
        run(mkcmd(0, 3, 0, 0, 32'h0000_0500, -512, 1'b0, 0));
        $display("test empty bitmap done");
        conclude();
    end

    initial begin
        repeat (40000) @(posedge clk);
        bad_count++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
endmodule : bitmap_fragment_rasterizer_tb_top

`default_nettype wire

/* File: verification/frag_sink.sv */
`timescale 1ns/1ps
`default_nettype none

// ------------------------------------------------------------
// Downstream fragment pipeline model
// ------------------------------------------------------------
module frag_sink (
    // Clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // Stall percentage, 0 accepts always, 100 never
    input wire logic [7:0] stall,
    // Fragment stream
    output logic frag_ready
);
    integer seed = 32'h8829_a700;

    // Ready may drop at any edge, like a busy pipeline
    always @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            frag_ready <= 1'b0;
        end else begin
            frag_ready <= ((($random(seed) & 32'h0000_7fff) % 100) >= stall);
        end
    end
endmodule : frag_sink

`default_nettype wire
